// *** core/fbso_pkg.sv ***
// Purpose: shared constants for the flash block-select, overlay and boot unit
// Assumes: 32-bit AXI4-Lite register map, 50 MHz system clock
// Notes: offsets are byte addresses on word boundaries
package fbso_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // register byte offsets
  localparam logic [7:0] OFF_MAIN_CTRL = 8'h00;
  localparam logic [7:0] OFF_UPPER_ERASE = 8'h04;
  localparam logic [7:0] OFF_OVERLAY = 8'h08;
  localparam logic [7:0] OFF_BOOT_STAT = 8'h0c;
  localparam logic [7:0] OFF_BOOT_CTRL = 8'h10;
  localparam logic [7:0] OFF_BAUD = 8'h14;
  // field positions
  localparam int SWE_BIT = 6;
  localparam int FWE_BIT = 7;
  localparam int OVL_SEL_BIT = 3;
  localparam int AREA_HI = 2;
  localparam int AREA_LO = 1;
  localparam logic [7:0] UPPER_ERASE_MASK = 8'h03;
  localparam logic [7:0] OVERLAY_WR_MASK = 8'h3f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // addresses, 24-bit space
  localparam logic [23:0] BLK8_BASE = 24'h010000;
  localparam logic [23:0] BLK9_BASE = 24'h018000;
  localparam logic [23:0] OVL_RAM_BASE = 24'hffe000;
  localparam logic [23:0] OVL_RAM_LAST = 24'hffe3ff;
  localparam logic [23:0] OVL_BLOCK_SIZE = 24'h000400;
  localparam logic [23:0] BOOT_RAM_BASE = 24'hffe800;
  localparam logic [23:0] BOOT_RAM_LAST = 24'hffefbf;
  // boot handshake bytes
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] ACK_BYTE = 8'h55;
  // timing
  localparam int unsigned BOOT_SETTLE_STATES = 100;
  localparam int unsigned MODE_SETUP_STATES = 4;
  localparam int unsigned FRAME_DATA_BITS = 8;
  // the all-zero byte holds rxd low for start plus eight data bits
  localparam int unsigned LOW_BITS_PER_SYNC = FRAME_DATA_BITS + 1;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : fbso_pkg

// *** core/fbso_uart_tx.sv ***
// Purpose: 8N1 serial transmitter for the boot channel
// Assumes: divisor plus one gives clocks per bit
// Notes: line idles high
`timescale 1ns/1ps
`default_nettype none
module fbso_uart_tx
  import fbso_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [DIV_W-1:0] bitDiv,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic txd
);
  logic [DIV_W-1:0] cnt_reg;
  logic [3:0] bitIdx_reg;
  logic [9:0] shift_reg;
  logic busy_reg;
  wire cntDone = (cnt_reg == '0);
  wire lastBit = (bitIdx_reg == 4'd9);

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      bitIdx_reg <= 4'd0;
      shift_reg <= 10'h3ff;
    end else if (!busy_reg) begin
      if (start) begin
        busy_reg <= 1'b1;
        shift_reg <= {1'b1, data, 1'b0};
        cnt_reg <= bitDiv;
        bitIdx_reg <= 4'd0;
      end
    end else if (cntDone) begin
      cnt_reg <= bitDiv;
      shift_reg <= {1'b1, shift_reg[9:1]};
      bitIdx_reg <= bitIdx_reg + 4'd1;
      if (lastBit) begin
        busy_reg <= 1'b0;
      end
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign busy = busy_reg;
  assign txd = busy_reg ? shift_reg[0] : 1'b1;
endmodule : fbso_uart_tx
`default_nettype wire

// *** core/fbso_uart_rx.sv ***
// Purpose: 8N1 serial receiver for the boot channel
// Assumes: rxd synchronous to clk
// Notes: samples mid-bit; bad stop bit flags frameErr
`timescale 1ns/1ps
`default_nettype none
module fbso_uart_rx
  import fbso_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [DIV_W-1:0] bitDiv,
  input wire logic rxd,
  output logic valid,
  output logic frameErr,
  output logic [7:0] data
);
  logic [DIV_W-1:0] cnt_reg;
  logic [3:0] bitIdx_reg;
  logic [7:0] shift_reg;
  logic active_reg;
  logic valid_reg;
  logic err_reg;
  logic [7:0] data_reg;
  wire cntDone = (cnt_reg == '0);

  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      active_reg <= 1'b0;
      cnt_reg <= '0;
      bitIdx_reg <= 4'd0;
      shift_reg <= 8'h00;
      valid_reg <= 1'b0;
      err_reg <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      valid_reg <= 1'b0;
      err_reg <= 1'b0;
      if (!active_reg) begin
        if (!rxd) begin
          active_reg <= 1'b1;
          cnt_reg <= bitDiv >> 1;
          bitIdx_reg <= 4'd0;
        end
      end else if (cntDone) begin
        cnt_reg <= bitDiv;
        bitIdx_reg <= bitIdx_reg + 4'd1;
        if (bitIdx_reg == 4'd0 && rxd) begin
          active_reg <= 1'b0;
        end else if (bitIdx_reg == 4'd9) begin
          active_reg <= 1'b0;
          valid_reg <= rxd;
          err_reg <= !rxd;
          data_reg <= shift_reg;
        end else if (bitIdx_reg != 4'd0) begin
          shift_reg <= {rxd, shift_reg[7:1]};
        end
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign valid = valid_reg;
  assign frameErr = err_reg;
  assign data = data_reg;
endmodule : fbso_uart_rx
`default_nettype wire

// *** core/fbso_flash_unit.sv ***
// Purpose: upper erase-block select, RAM overlay and boot-mode loader
// Assumes: AXI4-Lite slave, single clock, synchronous active-high reset
// Notes: loader writes RAM through a simple write port; erase is requested from the array
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fbso_flash_unit
  import fbso_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter int LOAD_LEN_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // mode straps and watchdog overflow
  input wire logic modePin2,
  input wire logic modePin1,
  input wire logic modePin0,
  input wire logic flashWritePin,
  input wire logic watchdogOverflow,
  // boot serial channel
  input wire logic rxd,
  output logic txd,
  // cpu address remap for overlay
  input wire logic [23:0] cpuAddr,
  output logic [23:0] mappedAddr,
  // flash array control
  input wire logic flashBusy,
  output logic programEraseEnable,
  output logic [9:0] eraseBlockSel,
  output logic chipEraseReq,
  output logic interruptBlock,
  // boot RAM loader write port, mode and hand-off status
  output logic ramWrEn,
  output logic [23:0] ramWrAddr,
  output logic [7:0] ramWrData,
  output logic bootMode,
  output logic userMode,
  output logic bootHandoff
);
  typedef enum logic [7:0] {
    BT_IDLE = 8'b0000_0001,
    BT_SETTLE = 8'b0000_0010,
    BT_MEASURE = 8'b0000_0100,
    BT_SYNC_TX = 8'b0000_1000,
    BT_WAIT_ACK = 8'b0001_0000,
    BT_LOAD = 8'b0010_0000,
    BT_ERASE = 8'b0100_0000,
    BT_DONE = 8'b1000_0000
  } fbso_boot_t;

  function automatic logic onehot0_multi(input logic [7:0] v);
    return (v & (v - 8'd1)) != 8'h00;
  endfunction

  logic [7:0] mainCtrl_reg, mainCtrl_next;
  logic [7:0] upperErase_reg, upperErase_next;
  logic [7:0] overlay_reg, overlay_next;
  logic [LOAD_LEN_W-1:0] loadLen_reg;
  logic [DIV_W-1:0] baud_reg;
  logic [DIV_W-1:0] lowCnt_reg;
  logic [7:0] settleCnt_reg;
  logic [2:0] rstHist_reg;
  logic bootMode_reg, userMode_reg;
  logic rxEn_reg, txEn_reg;
  logic [LOAD_LEN_W-1:0] loadCnt_reg;
  logic eraseSeen_reg;
  logic syncFail_reg;
  fbso_boot_t state_reg, state_next;

  // AXI write side: both channels may arrive in either order
  logic awHeld_reg, wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg, bresp_reg;

  assign s_axi_awready = !awHeld_reg && !bvalid_reg;
  assign s_axi_wready = !wHeld_reg && !bvalid_reg;
  wire doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  wire lane0 = wStrb_reg[0];
  wire [7:0] wrByte = wData_reg[7:0];
  wire wrMain = doWrite && lane0 && (awAddr_reg == OFF_MAIN_CTRL);
  wire wrUpper = doWrite && lane0 && (awAddr_reg == OFF_UPPER_ERASE);
  wire wrOverlay = doWrite && lane0 && (awAddr_reg == OFF_OVERLAY);
  wire wrBootCtrl = doWrite && (awAddr_reg == OFF_BOOT_CTRL);
  wire wrMapped = (awAddr_reg == OFF_MAIN_CTRL) || (awAddr_reg == OFF_UPPER_ERASE)
                  || (awAddr_reg == OFF_OVERLAY) || (awAddr_reg == OFF_BOOT_STAT)
                  || (awAddr_reg == OFF_BOOT_CTRL) || (awAddr_reg == OFF_BAUD);

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wrMapped ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  wire soft_write_enable = mainCtrl_reg[SWE_BIT];
  // overlay clears programEraseEnable; the boot chipEraseReq is not gated by it
  wire ovlOn = overlay_reg[OVL_SEL_BIT];

  always_comb begin
    mainCtrl_next = mainCtrl_reg;
    if (wrMain) begin
      mainCtrl_next = {1'b0, wrByte[SWE_BIT], 6'b00_0000};
    end
  end

  always_comb begin
    upperErase_next = upperErase_reg;
    if (wrUpper) begin
      upperErase_next = wrByte & UPPER_ERASE_MASK;
      if (onehot0_multi(upperErase_next)) begin
        upperErase_next = RESET_BYTE;
      end
    end
    // forced to zero without write enable
    if (!soft_write_enable) begin
      upperErase_next = RESET_BYTE;
    end
  end

  always_comb begin
    overlay_next = overlay_reg;
    // bits 7,6 never stored; 5,4 stored as written
    if (wrOverlay) begin
      overlay_next = wrByte & OVERLAY_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mainCtrl_reg <= RESET_BYTE;
      upperErase_reg <= RESET_BYTE;
      overlay_reg <= RESET_BYTE;
    end else begin
      mainCtrl_reg <= mainCtrl_next;
      upperErase_reg <= upperErase_next;
      overlay_reg <= overlay_next;
    end
  end

  // bit 1 is upper 32k block, bit 0 the lower
  assign eraseBlockSel = {upperErase_reg[1:0], 8'h00};
  assign programEraseEnable = soft_write_enable && !ovlOn && flashWritePin;

  // area bits choose 1-kbyte block; bit 0 ignored
  wire [1:0] areaSel = overlay_reg[AREA_HI:AREA_LO];
  wire [23:0] ovlFlashBase = OVL_BLOCK_SIZE * {22'd0, areaSel};
  wire inOvlFlash = ovlOn && (cpuAddr >= ovlFlashBase) && (cpuAddr < ovlFlashBase + OVL_BLOCK_SIZE);
  // substitute RAM fixed at one 1-kbyte window
  assign mappedAddr = inOvlFlash ? (OVL_RAM_BASE | (cpuAddr - ovlFlashBase)) : cpuAddr;

  // interrupts held off during program/erase and boot
  // busy flash means code must run from RAM, so flag it
  assign interruptBlock = flashBusy || chipEraseReq || (bootMode_reg && state_reg != BT_DONE);

  // straps sampled on the cycle reset is released
  wire stapUser = modePin2 && modePin1 && modePin0 && flashWritePin;
  wire strapBoot = !modePin2 && modePin1 && modePin0 && flashWritePin;
  always_ff @(posedge clk) begin
    if (rst) begin
      rstHist_reg <= 3'b111;
    end else begin
      rstHist_reg <= {rstHist_reg[1:0], 1'b0};
    end
  end
  wire rstEnded = rstHist_reg[0];

  // serial channel
  // 8N1 framing in both shifters
  logic rxValid, rxErr, txBusy;
  logic [7:0] rxData;
  logic txStart;
  logic [7:0] txData;
  fbso_uart_rx #(.DIV_W(DIV_W)) u_rx (
    .clk(clk), .rst(rst), .enable(rxEn_reg && state_reg != BT_MEASURE), .bitDiv(baud_reg),
    .rxd(rxd), .valid(rxValid), .frameErr(rxErr), .data(rxData)
  );
  fbso_uart_tx #(.DIV_W(DIV_W)) u_tx (
    .clk(clk), .rst(rst), .bitDiv(baud_reg), .start(txStart), .data(txData),
    .busy(txBusy), .txd(txd)
  );
  assign txStart = (state_reg == BT_SYNC_TX) && txEn_reg && !txBusy;
  assign txData = SYNC_BYTE;

  // low-run of a zero byte is nine bits
  wire [DIV_W-1:0] measuredDiv = DIV_W'(lowCnt_reg / LOW_BITS_PER_SYNC);
  wire loadLast = (loadCnt_reg == loadLen_reg - 1'b1) ||
                  (BOOT_RAM_BASE + 24'(loadCnt_reg) == BOOT_RAM_LAST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BT_IDLE: if (bootMode_reg) state_next = BT_SETTLE;
      // settle about 100 states; rxd is not checked
      BT_SETTLE: if (settleCnt_reg == 8'(BOOT_SETTLE_STATES)) state_next = BT_MEASURE;
      BT_MEASURE: if (rxd && lowCnt_reg != '0) state_next = BT_SYNC_TX;
      BT_SYNC_TX: if (txStart) state_next = BT_WAIT_ACK;
      BT_WAIT_ACK: if (rxValid && rxData == ACK_BYTE && !txBusy) state_next = BT_LOAD;
      BT_LOAD: if (rxValid && loadLast) state_next = BT_ERASE;
      BT_ERASE: if (eraseSeen_reg && !flashBusy) state_next = BT_DONE;
      BT_DONE: state_next = BT_DONE;
      default: state_next = BT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bootMode_reg <= 1'b0;
      userMode_reg <= 1'b0;
      state_reg <= BT_IDLE;
      settleCnt_reg <= 8'h00;
      lowCnt_reg <= '0;
      baud_reg <= '0;
      rxEn_reg <= 1'b0;
      txEn_reg <= 1'b0;
      loadCnt_reg <= '0;
      loadLen_reg <= '1;
      eraseSeen_reg <= 1'b0;
      syncFail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (rstEnded) begin
        bootMode_reg <= strapBoot;
        userMode_reg <= stapUser;
      end else if (watchdogOverflow) begin
        bootMode_reg <= 1'b0;
        state_reg <= BT_IDLE;
      end
      if (state_reg == BT_SETTLE) settleCnt_reg <= settleCnt_reg + 8'd1;
      if (state_reg == BT_MEASURE && !rxd) lowCnt_reg <= lowCnt_reg + 1'b1;
      if (state_reg == BT_MEASURE && state_next == BT_SYNC_TX) begin
        baud_reg <= measuredDiv;
        rxEn_reg <= 1'b1;
        txEn_reg <= 1'b1;
      end
      if (wrBootCtrl && wStrb_reg[1:0] == 2'b11 && state_reg != BT_LOAD) begin
        loadLen_reg <= wData_reg[LOAD_LEN_W-1:0];
      end
      if (state_reg == BT_WAIT_ACK && rxErr) syncFail_reg <= 1'b1;
      // bytes stored from the boot area base
      if (state_reg == BT_LOAD && rxValid) loadCnt_reg <= loadCnt_reg + 1'b1;
      if (state_reg == BT_ERASE && flashBusy) eraseSeen_reg <= 1'b1;
      // serial enables dropped on entering BT_ERASE, divisor kept
      if (state_next == BT_ERASE) begin
        rxEn_reg <= 1'b0;
        txEn_reg <= 1'b0;
      end
    end
  end

  assign ramWrEn = (state_reg == BT_LOAD) && rxValid;
  assign ramWrAddr = BOOT_RAM_BASE + 24'(loadCnt_reg);
  assign ramWrData = rxData;
  assign chipEraseReq = (state_reg == BT_ERASE) && !eraseSeen_reg;
  assign bootMode = bootMode_reg;
  assign userMode = userMode_reg;
  assign bootHandoff = (state_reg == BT_DONE);

  // read side
  logic [31:0] rdMux;
  logic rdOk;
  always_comb begin
    rdMux = 32'h0000_0000;
    rdOk = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      OFF_MAIN_CTRL: rdMux = {24'h0, flashWritePin, mainCtrl_reg[SWE_BIT], 6'h00};
      OFF_UPPER_ERASE: rdMux = {24'h0, upperErase_reg};
      OFF_OVERLAY: rdMux = {24'h0, overlay_reg};
      OFF_BOOT_STAT: rdMux = {16'h0, state_reg, 3'b000, syncFail_reg, rxEn_reg, txEn_reg,
                              userMode_reg, bootMode_reg};
      OFF_BOOT_CTRL: rdMux = 32'(loadLen_reg);
      OFF_BAUD: rdMux = 32'(baud_reg);
      default: rdOk = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= AXI_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdMux;
      rresp_reg <= rdOk ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule : fbso_flash_unit
`default_nettype wire

// *** verif/fbso_flash_unit_chk.sv ***
// Purpose: port-level checks for fbso_flash_unit
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto the unit at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fbso_flash_unit_chk
  import fbso_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic flashWritePin,
  input wire logic watchdogOverflow,
  input wire logic txd,
  input wire logic [23:0] cpuAddr,
  input wire logic [23:0] mappedAddr,
  input wire logic flashBusy,
  input wire logic programEraseEnable,
  input wire logic [9:0] eraseBlockSel,
  input wire logic chipEraseReq,
  input wire logic interruptBlock,
  input wire logic ramWrEn,
  input wire logic [23:0] ramWrAddr,
  input wire logic bootMode,
  input wire logic userMode,
  input wire logic bootHandoff
);
  logic erasedReg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // remembers that the array took the chip erase
  always_ff @(posedge clk) begin
    erasedReg <= rst ? 1'b0 : (erasedReg | (chipEraseReq & flashBusy));
  end
  property p_eraseSel;
    eraseBlockSel[7:0] == 8'h00 && !(eraseBlockSel[9] && eraseBlockSel[8]);
  endproperty
  a_eraseSel: assert property (p_eraseSel) else $error("two upper blocks selected");
  property p_ovlMap;
    mappedAddr != cpuAddr |-> mappedAddr == {14'h3ff8, cpuAddr[9:0]} && cpuAddr[23:12] == 12'h000;
  endproperty
  a_ovlMap: assert property (p_ovlMap) else $error("overlay remap outside fixed window");
  property p_ovlProt;
    mappedAddr != cpuAddr |-> !programEraseEnable;
  endproperty
  a_ovlProt: assert property (p_ovlProt) else $error("program enabled under overlay");
  property p_pePin;
    programEraseEnable |-> flashWritePin;
  endproperty
  a_pePin: assert property (p_pePin) else $error("program enabled with write pin low");
  property p_ramRange;
    ramWrEn |-> ramWrAddr >= BOOT_RAM_BASE && ramWrAddr <= BOOT_RAM_LAST;
  endproperty
  a_ramRange: assert property (p_ramRange) else $error("load write outside boot area");
  property p_ramBoot;
    ramWrEn |-> bootMode && !bootHandoff;
  endproperty
  a_ramBoot: assert property (p_ramBoot) else $error("load write outside boot load");
  property p_irq;
    flashBusy || chipEraseReq |-> interruptBlock;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupts open during erase");
  property p_modeExcl;
    !(bootMode && userMode);
  endproperty
  a_modeExcl: assert property (p_modeExcl) else $error("boot and user both set");
  property p_handTx;
    bootHandoff |-> txd && erasedReg;
  endproperty
  a_handTx: assert property (p_handTx) else $error("hand-off with line low or no erase");
  property p_wdog;
    watchdogOverflow |-> ##[1:2] !bootMode;
  endproperty
  a_wdog: assert property (p_wdog) else $error("boot kept after watchdog overflow");
endmodule : fbso_flash_unit_chk
bind fbso_flash_unit fbso_flash_unit_chk u_chk (.clk, .rst, .flashWritePin, .watchdogOverflow, .txd,
  .cpuAddr, .mappedAddr, .flashBusy, .programEraseEnable, .eraseBlockSel, .chipEraseReq,
  .interruptBlock, .ramWrEn, .ramWrAddr, .bootMode, .userMode, .bootHandoff);
`default_nettype wire

// *** verif/fbso_host_model.sv ***
// Purpose: serial host for the boot handshake and program download
// Assumes: 8N1 at a fixed bit time in clk cycles
// Notes: rxd idles high as with a board pull-up
`timescale 1ns/1ps
`default_nettype none
module fbso_host_model
  import fbso_pkg::*;
#(
  parameter int BIT_CLKS = 64,
  parameter int PROG_LEN = 3
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic go,
  output logic rxd,
  output logic gotSync
);
  logic [7:0] rxByte;
  // start, data lsb first, one stop
  task automatic sendByte(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : sendByte
  initial begin
    rxd <= 1'b1;
    wait (go === 1'b1);
    @(posedge clk);
    // zero bytes, bit time kept short for run length
    while (gotSync !== 1'b1) sendByte(SYNC_BYTE);
    sendByte(ACK_BYTE);
    for (int i = 0; i < PROG_LEN; i++) sendByte(8'h10 + i[7:0]);
  end
  // check the device byte arrived intact
  initial begin
    gotSync = 1'b0;
    forever begin
      @(negedge txd);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        rxByte[i] = txd;
      end
      repeat (BIT_CLKS) @(posedge clk);
      if (txd === 1'b1 && rxByte === SYNC_BYTE) gotSync = 1'b1;
    end
  end
endmodule : fbso_host_model
`default_nettype wire

// *** verif/fbso_flash_unit_tb_top.sv ***
// Purpose: self-checking bench for fbso_flash_unit
// Assumes: AXI4-Lite master tasks, host model on the serial pins
// Notes: ready sampled on the falling edge, acted on after the rising edge
`timescale 1ns/1ps
`default_nettype none
module fbso_flash_unit_tb_top;
  import fbso_pkg::*;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, hostGo, gotSync;
  logic modePin2, modePin1, modePin0, flashWritePin, watchdogOverflow, rxd, txd, flashBusy;
  logic programEraseEnable, chipEraseReq, interruptBlock, ramWrEn, bootMode, userMode, bootHandoff;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ramWrData, firstData;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, baud;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [23:0] cpuAddr, mappedAddr, ramWrAddr, firstAddr;
  logic [9:0] eraseBlockSel;
  int num_errors, compares, ramCount;
  fbso_flash_unit u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .modePin2,
    .modePin1, .modePin0, .flashWritePin, .watchdogOverflow, .rxd, .txd, .cpuAddr, .mappedAddr, .flashBusy,
    .programEraseEnable, .eraseBlockSel, .chipEraseReq, .interruptBlock, .ramWrEn, .ramWrAddr, .ramWrData,
    .bootMode, .userMode, .bootHandoff);
  fbso_host_model u_host (.clk, .txd, .go(hostGo), .rxd, .gotSync);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ramWrEn === 1'b1 && ramCount++ == 0) {firstAddr, firstData} = {ramWrAddr, ramWrData};
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
  endtask : clks
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw, hb;
    int n;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} <= {a, d, s, 2'b11};
    {pa, pw, hb, n} = '0;
    do begin
      @(negedge clk);
      pa = pa | s_axi_awready;
      pw = pw | s_axi_wready;
      @(posedge clk);
      {s_axi_awvalid, s_axi_wvalid} <= {~pa, ~pw};
    end while (!(pa && pw) && n++ < 100);
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      {hb, rr} = {s_axi_bvalid, s_axi_bresp};
      @(posedge clk);
    end while (!hb && n++ < 200);
    s_axi_bready <= 1'b0;
    chk("bresp", {1'b1, AXI_OKAY}, {hb, rr});
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a);
    logic h;
    int n;
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    n = 0;
    do begin
      @(negedge clk);
      h = s_axi_arready;
      @(posedge clk);
    end while (!h && n++ < 100);
    {s_axi_arvalid, s_axi_rready} <= 2'b01;
    do begin
      @(negedge clk);
      {h, rd, rr} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk);
    end while (!h && n++ < 200);
    s_axi_rready <= 1'b0;
    if (!h) num_errors++;
  endtask : axiRd
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    axiRd(a);
    chk("register read", exp, rd);
  endtask : rdChk
  task automatic tUser;
    chk("user mode", 1'b1, userMode & ~bootMode);
    axiWr(OFF_MAIN_CTRL, 32'h40, 4'hf);
    rdChk(OFF_MAIN_CTRL, 32'hc0);
    chk("pe enable", 1'b1, programEraseEnable);
    axiWr(OFF_UPPER_ERASE, 32'h01, 4'hf);
    rdChk(OFF_UPPER_ERASE, 32'h01);
    chk("block sel", 10'h100, eraseBlockSel);
    axiWr(OFF_UPPER_ERASE, 32'h02, 4'hf);
    chk("block sel", 10'h200, eraseBlockSel);
    axiWr(OFF_UPPER_ERASE, 32'h03, 4'hf);
    rdChk(OFF_UPPER_ERASE, 32'h00);
    axiWr(OFF_UPPER_ERASE, 32'h04, 4'hf);
    rdChk(OFF_UPPER_ERASE, 32'h00);
    axiWr(OFF_UPPER_ERASE, 32'h01, 4'hf);
    axiWr(OFF_MAIN_CTRL, 32'h00, 4'hf);
    rdChk(OFF_UPPER_ERASE, 32'h00);
    chk("pe enable", 1'b0, programEraseEnable);
    axiRd(8'h20);
    chk("unmapped rresp", AXI_SLVERR, rr);
    $display("test user registers done");
  endtask : tUser
  task automatic tOverlay;
    axiWr(OFF_MAIN_CTRL, 32'h40, 4'hf);
    axiWr(OFF_OVERLAY, 32'hcf, 4'hf);
    rdChk(OFF_OVERLAY, 32'h0f);
    chk("pe overlay", 1'b0, programEraseEnable);
    for (int i = 0; i < 4; i++) begin
      axiWr(OFF_OVERLAY, {28'h0, 1'b1, i[1:0], i[0]}, 4'hf);
      // one idle cycle before the remapped access
      clks(1);
      cpuAddr <= {12'h000, i[1:0], 10'h123};
      @(negedge clk);
      chk("remap", {OVL_RAM_BASE[23:10], 10'h123}, mappedAddr);
      @(posedge clk);
      cpuAddr <= {12'h000, ~i[1:0], 10'h123};
      @(negedge clk);
      chk("no remap", {12'h000, ~i[1:0], 10'h123}, mappedAddr);
      @(posedge clk);
    end
    axiWr(OFF_OVERLAY, 32'h00, 4'hf);
    chk("pe restored", 1'b1, programEraseEnable);
    chk("overlay off", {12'h000, 2'b00, 10'h123}, mappedAddr);
    $display("test overlay done");
  endtask : tOverlay
  task automatic tBoot;
    int n;
    rst <= 1'b1;
    // reset high 20 states before the pins move
    clks(20);
    modePin2 <= 1'b0;
    clks(6);
    rst <= 1'b0;
    clks(3);
    chk("boot mode", 1'b1, bootMode & ~userMode);
    axiWr(OFF_BOOT_CTRL, 32'h3, 4'h3);
    // settle window before the host starts
    clks(110);
    hostGo <= 1'b1;
    for (n = 0; gotSync !== 1'b1 && n < 5000; n++) clks(1);
    chk("match byte seen", 1'b1, gotSync);
    axiRd(OFF_BAUD);
    baud = rd;
    chk("baud matched", 1'b1, rd >= 32'd58 && rd <= 32'd68);
    for (n = 0; chipEraseReq !== 1'b1 && n < 20000; n++) clks(1);
    chk("erase after load", 1'b1, chipEraseReq && ramCount == 3);
    chk("first load addr", BOOT_RAM_BASE, firstAddr);
    chk("first load data", 8'h10, firstData);
    flashBusy <= 1'b1;
    clks(20);
    chk("irq blocked", 1'b1, interruptBlock);
    flashBusy <= 1'b0;
    for (n = 0; bootHandoff !== 1'b1 && n < 2000; n++) clks(1);
    chk("handoff txd high", 2'b11, {bootHandoff, txd});
    axiRd(OFF_BOOT_STAT);
    chk("rx tx enables", 2'b00, rd[3:2]);
    axiRd(OFF_BAUD);
    chk("baud kept", baud, rd);
    watchdogOverflow <= 1'b1;
    clks(1);
    watchdogOverflow <= 1'b0;
    clks(2);
    chk("boot left", 1'b0, bootMode);
    $display("test boot done");
  endtask : tBoot
  initial begin
    {rst, modePin2, modePin1, modePin0, flashWritePin} = 5'h1f;
    {watchdogOverflow, flashBusy, cpuAddr, hostGo} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {num_errors, compares, ramCount} = '0;
    clks(12);
    rst <= 1'b0;
    clks(3);
    tUser;
    tOverlay;
    tBoot;
    results;
  end
  initial begin
    clks(90000);
    num_errors++;
    results;
  end
endmodule : fbso_flash_unit_tb_top
`default_nettype wire
